//--- logic/tsc_pkg.sv
// Package of constants and types for the temperature sensor control block
package tsc_pkg;
	// Register pointer values
	localparam logic [7:0] ADDR_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_HIGH = 8'h02;
	localparam logic [7:0] ADDR_LOW = 8'h03;
	localparam logic [7:0] ADDR_CRIT = 8'h04;
	localparam logic [7:0] ADDR_TEMP = 8'h05;
	// Configuration field positions
	localparam int CFG_HYSTERESIS_SELECT_HI = 10;
	localparam int CFG_HYSTERESIS_SELECT_LO = 9;
	localparam int CFG_OFF = 8;
	localparam int CFG_CLOCK = 7;
	localparam int CFG_ALOCK = 6;
	localparam int CFG_CLEAR = 5;
	localparam int CFG_STS = 4;
	localparam int CFG_EN = 3;
	localparam int CFG_CONLY = 2;
	localparam int CFG_POL = 1;
	localparam int CFG_MODE = 0;
	// Temperature register status positions
	localparam int TMP_CRIT = 15;
	localparam int TMP_HIGH = 14;
	localparam int TMP_LOW = 13;
	// Limits keep bits 12..2, temperature 12..0
	localparam logic [12:0] LIMIT_MASK = 13'h1FFC;
	// Supported resolution: 2'b11 is 0.0625 degree
	localparam logic [1:0] RES_CAP = 2'h3;
	// Reset values
	localparam logic [12:0] VAL_RESET = 13'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	// Hysteresis in 0.0625 degree steps
	localparam logic [6:0] HYSTERESIS_SELECT_NONE = 7'h00;
	localparam logic [6:0] HYSTERESIS_SELECT_1P5 = 7'h18;
	localparam logic [6:0] HYSTERESIS_SELECT_3 = 7'h30;
	localparam logic [6:0] HYSTERESIS_SELECT_6 = 7'h60;

	// Byte assembly states of the write path
	typedef enum logic [3:0] {
		ST_PTR = 4'h1,
		ST_MSB = 4'h2,
		ST_LSB = 4'h4,
		ST_DONE = 4'h8
	} tsc_wr_e;

	// Byte from the serial engine
	typedef struct packed {
		logic start;
		logic valid;
		logic [7:0] data;
	} tsc_byte_s;

	// Two-flop synchroniser plus edge history
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} tsc_sync_s;

	// Main block state
	typedef struct packed {
		tsc_wr_e wr;
		logic [7:0] ptr;
		logic [7:0] msb;
		logic [1:0] hysteresis_select;
		logic off;
		logic clock;
		logic alock;
		logic en;
		logic conly;
		logic pol;
		logic mode;
		logic [12:0] hi;
		logic [12:0] lo;
		logic [12:0] cr;
		logic [12:0] temp;
		logic hi_trip;
		logic lo_trip;
		logic cr_trip;
		logic win_prev;
		logic latch;
		logic clr_pend;
		logic event_q;
		logic oe;
		logic [15:0] rd_word;
	} tsc_state_s;
endpackage : tsc_pkg

//--- logic/tsc_sync.sv
// Two-flop synchroniser with edge detector for the converter toggle
`timescale 1ns/1ps
`default_nettype none
module tsc_sync (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic edge_o
);
	import tsc_pkg::*;
	tsc_sync_s q_q;
	tsc_sync_s q_d;

	// First flop feeds only the second; edge looks at later stages
	always_comb begin
		q_d.s1 = async_i;
		q_d.s2 = q_q.s1;
		q_d.s3 = q_q.s2;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end

	// Either direction of the toggle marks a new sample
	assign edge_o = q_q.s2 ^ q_q.s3;
endmodule : tsc_sync
`default_nettype wire

//--- logic/tsc_limit_cmp.sv
// Limit comparator with hysteresis on release
`timescale 1ns/1ps
`default_nettype none
module tsc_limit_cmp #(
	parameter bit BELOW = 1'b0
) (
	input wire logic [12:0] value_i,
	input wire logic [12:0] limit_i,
	input wire logic [6:0] hysteresis_select_i,
	input wire logic trip_i,
	output logic trip_o
);
	import tsc_pkg::*;
	logic signed [13:0] v;
	logic signed [13:0] l;
	logic signed [13:0] h;

	// One extra bit keeps limit plus or minus hysteresis from wrapping
	always_comb begin
		v = {value_i[12], value_i};
		l = {limit_i[12], limit_i};
		h = {7'h00, hysteresis_select_i};
		if (BELOW) begin
			trip_o = trip_i ? (v < l + h) : (v < l);
		end else begin
			trip_o = trip_i ? (v > l - h) : (v > l);
		end
	end
endmodule : tsc_limit_cmp
`default_nettype wire

//--- logic/tsc_ctrl.sv
// Configuration, limit, temperature registers and alert pin logic
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire tsc_pkg::tsc_byte_s wr_byte_i,
	output logic [15:0] rd_word_o,
	input wire logic sample_toggle_i,
	input wire logic [12:0] sample_temp_i,
	output logic conv_enable_o,
	input wire logic alert_i,
	output logic alert_o,
	output logic alert_oe_o
);
	import tsc_pkg::*;

	tsc_state_s s_q;
	tsc_state_s s_d;
	logic sample_edge;
	logic [6:0] hysteresis_select_amt;
	logic hi_trip_d;
	logic lo_trip_d;
	logic cr_trip_d;
	logic locked;
	logic commit;
	logic [15:0] wdata;
	logic clear_req;
	logic win_now;
	logic alert_raw;
	logic [12:0] temp_masked;
	logic [15:0] cfg_word;
	logic [15:0] temp_word;

	// Signed compare used by all status bits
	function automatic logic sgt(input logic [12:0] a, input logic [12:0] b);
		sgt = $signed(a) > $signed(b);
	endfunction : sgt

	// Resolution mask for fraction bits
	function automatic logic [12:0] res_mask(input logic [1:0] res);
		case (res)
			2'h0: res_mask = 13'h1FF8;
			2'h1: res_mask = 13'h1FFC;
			2'h2: res_mask = 13'h1FFE;
			default: res_mask = 13'h1FFF;
		endcase
	endfunction : res_mask

	// Converter toggle comes from another domain
	tsc_sync u_sync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.async_i(sample_toggle_i),
		.edge_o(sample_edge)
	);

	// Hysteresis selector decode
	always_comb begin
		case (s_q.hysteresis_select)
			2'h0: hysteresis_select_amt = HYSTERESIS_SELECT_NONE;
			2'h1: hysteresis_select_amt = HYSTERESIS_SELECT_1P5;
			2'h2: hysteresis_select_amt = HYSTERESIS_SELECT_3;
			default: hysteresis_select_amt = HYSTERESIS_SELECT_6;
		endcase
	end

	// Window and critical comparators run every cycle, so a limit
	// write is seen on the next edge without waiting for a sample
	tsc_limit_cmp #(.BELOW(1'b0)) u_hi (
		.value_i(s_q.temp),
		.limit_i(s_q.hi),
		.hysteresis_select_i(hysteresis_select_amt),
		.trip_i(s_q.hi_trip),
		.trip_o(hi_trip_d)
	);

	tsc_limit_cmp #(.BELOW(1'b1)) u_lo (
		.value_i(s_q.temp),
		.limit_i(s_q.lo),
		.hysteresis_select_i(hysteresis_select_amt),
		.trip_i(s_q.lo_trip),
		.trip_o(lo_trip_d)
	);

	tsc_limit_cmp #(.BELOW(1'b0)) u_cr (
		.value_i(s_q.temp),
		.limit_i(s_q.cr),
		.hysteresis_select_i(hysteresis_select_amt),
		.trip_i(s_q.cr_trip),
		.trip_o(cr_trip_d)
	);

	// Write decode helpers
	always_comb begin
		locked = s_q.clock | s_q.alock;
		commit = wr_byte_i.valid & ~wr_byte_i.start & (s_q.wr == ST_LSB);
		wdata = {s_q.msb, wr_byte_i.data};
		clear_req = commit & (s_q.ptr == ADDR_CONFIG) & wdata[CFG_CLEAR];
		win_now = hi_trip_d | lo_trip_d;
		temp_masked = s_q.temp & res_mask(RES_CAP);
	end

	// Readback words
	always_comb begin
		cfg_word = WORD_RESET;
		cfg_word[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO] = s_q.hysteresis_select;
		cfg_word[CFG_OFF] = s_q.off;
		cfg_word[CFG_CLOCK] = s_q.clock;
		cfg_word[CFG_ALOCK] = s_q.alock;
		cfg_word[CFG_CLEAR] = 1'b0;
		cfg_word[CFG_STS] = s_q.en & s_q.event_q;
		cfg_word[CFG_EN] = s_q.en;
		cfg_word[CFG_CONLY] = s_q.conly;
		cfg_word[CFG_POL] = s_q.pol;
		cfg_word[CFG_MODE] = s_q.mode;
		temp_word = {3'h0, temp_masked};
		temp_word[TMP_CRIT] = ~sgt(s_q.cr, s_q.temp);
		temp_word[TMP_HIGH] = sgt(s_q.temp, s_q.hi);
		temp_word[TMP_LOW] = sgt(s_q.lo, s_q.temp);
	end

	// Raw event before latching, per mode
	always_comb begin
		if (s_q.conly) begin
			alert_raw = cr_trip_d;
		end else if (!s_q.mode) begin
			alert_raw = win_now | cr_trip_d;
		end else begin
			alert_raw = s_q.latch | cr_trip_d;
		end
	end

	// Next-state logic for the whole block
	always_comb begin
		s_d = s_q;

		// Byte assembly: pointer, then MSB, then LSB
		if (wr_byte_i.valid) begin
			if (wr_byte_i.start) begin
				s_d.ptr = wr_byte_i.data;
				s_d.wr = ST_MSB;
			end else begin
				case (s_q.wr)
					ST_PTR: begin
						s_d.ptr = wr_byte_i.data;
						s_d.wr = ST_MSB;
					end
					ST_MSB: begin
						s_d.msb = wr_byte_i.data;
						s_d.wr = ST_LSB;
					end
					ST_LSB: begin
						s_d.wr = ST_DONE;
					end
					default: begin
						s_d.wr = ST_DONE;
					end
				endcase
			end
		end

		// Register writes; locks use the values before this write
		if (commit) begin
			if (s_q.ptr == ADDR_CONFIG) begin
				if (!locked) begin
					s_d.hysteresis_select = wdata[CFG_HYSTERESIS_SELECT_HI:CFG_HYSTERESIS_SELECT_LO];
					s_d.en = wdata[CFG_EN];
					s_d.pol = wdata[CFG_POL];
					s_d.mode = wdata[CFG_MODE];
				end
				// Clearing the off bit is always allowed
				s_d.off = wdata[CFG_OFF] & (s_q.off | ~locked);
				s_d.conly = wdata[CFG_CONLY] & (s_q.conly | ~s_q.alock);
				s_d.clock = s_q.clock | wdata[CFG_CLOCK];
				s_d.alock = s_q.alock | wdata[CFG_ALOCK];
			end else if (s_q.ptr == ADDR_HIGH) begin
				if (!s_q.alock) begin
					s_d.hi = wdata[12:0] & LIMIT_MASK;
				end
			end else if (s_q.ptr == ADDR_LOW) begin
				if (!s_q.alock) begin
					s_d.lo = wdata[12:0] & LIMIT_MASK;
				end
			end else if (s_q.ptr == ADDR_CRIT) begin
				if (!s_q.clock) begin
					s_d.cr = wdata[12:0] & LIMIT_MASK;
				end
			end
		end

		// New samples are dropped while the sensor is off
		if (sample_edge && !s_q.off) begin
			s_d.temp = sample_temp_i;
		end

		// Comparator states with hysteresis
		s_d.hi_trip = hi_trip_d;
		s_d.lo_trip = lo_trip_d;
		s_d.cr_trip = cr_trip_d;
		s_d.win_prev = win_now;

		// Interrupt latch: clear first, so a crossing in the
		// same cycle sets it again and is not lost
		if (s_q.mode && !s_q.conly) begin
			if (clear_req) begin
				if (cr_trip_d) begin
					s_d.clr_pend = 1'b1;
				end else begin
					s_d.latch = 1'b0;
				end
			end else if (s_q.clr_pend && !cr_trip_d) begin
				s_d.latch = 1'b0;
				s_d.clr_pend = 1'b0;
			end
			if (win_now != s_q.win_prev) begin
				s_d.latch = 1'b1;
			end
		end else begin
			// Comparator or critical-only: clears have no effect
			s_d.latch = 1'b0;
			s_d.clr_pend = 1'b0;
		end

		// Alert is frozen during shutdown, except by an interrupt-mode clear below critical
		if (!s_q.off) begin
			s_d.event_q = alert_raw;
		end else if (clear_req && s_q.mode && !s_q.conly && !cr_trip_d) begin
			s_d.event_q = 1'b0;
		end

		// Open-drain pin: enable high pulls the line low
		if (!s_d.en) begin
			s_d.oe = s_d.pol;
		end else begin
			s_d.oe = s_d.pol ^ s_d.event_q;
		end

		// Read word for the current pointer
		if (s_q.ptr == ADDR_CONFIG) begin
			s_d.rd_word = cfg_word;
		end else if (s_q.ptr == ADDR_HIGH) begin
			s_d.rd_word = {3'h0, s_q.hi};
		end else if (s_q.ptr == ADDR_LOW) begin
			s_d.rd_word = {3'h0, s_q.lo};
		end else if (s_q.ptr == ADDR_CRIT) begin
			s_d.rd_word = {3'h0, s_q.cr};
		end else if (s_q.ptr == ADDR_TEMP) begin
			s_d.rd_word = temp_word;
		end else begin
			s_d.rd_word = WORD_RESET;
		end
	end

	// State register; power-on reset clears every field and lock except the write state, which starts at ST_PTR
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_q <= '0;
			s_q.wr <= ST_PTR;
			s_q.hi <= VAL_RESET;
			s_q.lo <= VAL_RESET;
			s_q.cr <= VAL_RESET;
			s_q.temp <= VAL_RESET;
			s_q.rd_word <= WORD_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; the pin itself is only ever pulled low
	assign rd_word_o = s_q.rd_word;
	assign conv_enable_o = ~s_q.off;
	assign alert_o = 1'b0;
	assign alert_oe_o = s_q.oe;

	// The pin level is not sampled; status comes from internal state
	logic unused_alert;
	assign unused_alert = alert_i;
endmodule : tsc_ctrl
`default_nettype wire

//--- verif/tsc_conv_model.sv
// Converter model feeding readings and a toggle to the block
`timescale 1ns/1ps
`default_nettype none
module tsc_conv_model (
	input wire logic run_i,
	input wire logic [12:0] want_i,
	output logic toggle_o,
	output logic [12:0] temp_o
);
	logic lclk = 1'b0;
	logic ph = 1'b0;
	logic t_q = 1'b0;
	logic [12:0] v_q = 13'h0000;
	assign toggle_o = t_q;
	assign temp_o = v_q;
	// Link clock, eight system clock periods long; it rises on a falling edge of the system clock
	always #32 lclk = ~lclk;
	// Reading moves a full link period before its toggle so it is still when captured
	always @(posedge lclk) begin
		if (run_i) begin
			ph <= ~ph;
			if (ph) t_q <= ~t_q;
			else v_q <= want_i;
		end
	end
endmodule : tsc_conv_model
`default_nettype wire

//--- verif/tsc_ctrl_props.sv
// Checker of register views and alert pin of the control block
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl_props (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire tsc_pkg::tsc_byte_s wr_byte_i,
	input wire logic [15:0] rd_word_o,
	input wire logic conv_enable_o,
	input wire logic alert_o,
	input wire logic alert_oe_o
);
	import tsc_pkg::*;
	logic [7:0] ptr_q;
	logic [7:0] pp_q;
	logic [15:0] pr_q;
	logic pcv_q;
	logic cv;
	logic lv;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Pointer tracked from the frames; the view lags it by one edge
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ptr_q <= 8'h00;
			pp_q <= 8'h00;
			pr_q <= 16'h0000;
			pcv_q <= 1'b0;
		end else begin
			if (wr_byte_i.valid && wr_byte_i.start) ptr_q <= wr_byte_i.data;
			pp_q <= ptr_q;
			pr_q <= rd_word_o;
			pcv_q <= cv;
		end
	end
	assign cv = (ptr_q == ADDR_CONFIG) && (pp_q == ADDR_CONFIG);
	assign lv = (ptr_q == pp_q) && (ptr_q inside {ADDR_HIGH, ADDR_LOW, ADDR_CRIT});
	// Unlocked configuration frame: pointer, high byte, low byte
	sequence cfg_frame_s;
		(wr_byte_i.valid && wr_byte_i.start && wr_byte_i.data == ADDR_CONFIG)
		##1 (wr_byte_i.valid && !wr_byte_i.start)
		##1 (wr_byte_i.valid && !wr_byte_i.start && rd_word_o[7:6] == 2'h0);
	endsequence
	cfg_write_a: assert property (
		cfg_frame_s |-> ##2 rd_word_o[10:8] == $past(wr_byte_i.data[2:0], 3)
		&& rd_word_o[3:0] == $past(wr_byte_i.data[3:0], 2))
		else $error("config write not applied");
	reserved_zero_a: assert property (
		cv |-> rd_word_o[15:11] == 5'h00 && !rd_word_o[5])
		else $error("reserved or clear bit reads one");
	limit_format_a: assert property (
		lv |-> rd_word_o[15:13] == 3'h0 && rd_word_o[1:0] == 2'h0)
		else $error("limit padding bits not zero");
	lock_sticky_a: assert property (
		cv && pcv_q |-> (rd_word_o[7:6] & pr_q[7:6]) == pr_q[7:6])
		else $error("lock bit cleared without reset");
	lock_freeze_a: assert property (
		cv && pcv_q && (pr_q[7] || pr_q[6]) |-> rd_word_o[10:9] == pr_q[10:9]
		&& rd_word_o[3] == pr_q[3] && rd_word_o[1:0] == pr_q[1:0])
		else $error("locked field changed");
	off_refused_a: assert property (
		cv && pcv_q && (pr_q[7] || pr_q[6]) && !pr_q[8] |-> !rd_word_o[8])
		else $error("shutdown set while locked");
	conly_refused_a: assert property (
		cv && pcv_q && pr_q[6] && !pr_q[2] |-> !rd_word_o[2])
		else $error("critical-only set under alarm lock");
	pin_status_a: assert property (
		cv && pcv_q && rd_word_o == pr_q && $stable(alert_oe_o)
		&& $past(alert_oe_o, 2) == alert_oe_o |-> alert_oe_o ==
		(rd_word_o[3] ? rd_word_o[4] ^ rd_word_o[1] : rd_word_o[1]))
		else $error("pin drive disagrees with config");
	conv_follow_a: assert property (
		cv && pcv_q && rd_word_o == pr_q && $stable(conv_enable_o)
		|-> conv_enable_o == !rd_word_o[8])
		else $error("converter enable wrong");
	open_drain_a: assert property (alert_oe_o |-> !alert_o)
		else $error("pin driven high");
endmodule : tsc_ctrl_props
bind tsc_ctrl tsc_ctrl_props u_props (.clock_i(clock_i), .reset_i(reset_i),
	.wr_byte_i(wr_byte_i), .rd_word_o(rd_word_o), .conv_enable_o(conv_enable_o),
	.alert_o(alert_o), .alert_oe_o(alert_oe_o));
`default_nettype wire

//--- verif/test_temp_sensor_config_limits_alert.sv
// Testbench of the control block: register frames, converter and alert pin
`timescale 1ns/1ps
`default_nettype none
module test_temp_sensor_config_limits_alert;
	import tsc_pkg::*;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	tsc_byte_s wb = '0;
	logic [15:0] rd_w;
	logic tgl;
	logic [12:0] stemp;
	logic [12:0] want = 13'h0000;
	logic conv_en;
	logic a_o;
	logic a_oe;
	wire logic pin;
	int bad_count = 0;
	int n_tests = 0;
	int i;
	logic [6:0] hv [4] = '{HYSTERESIS_SELECT_NONE, HYSTERESIS_SELECT_1P5, HYSTERESIS_SELECT_3, HYSTERESIS_SELECT_6};
	always #4 clock_i = ~clock_i;
	// Pull-up on the pin; the block can only pull it low
	assign pin = a_oe ? a_o : 1'b1;
	tsc_ctrl DUT (.clock_i(clock_i), .reset_i(reset_i), .wr_byte_i(wb), .rd_word_o(rd_w),
		.sample_toggle_i(tgl), .sample_temp_i(stemp), .conv_enable_o(conv_en),
		.alert_i(pin), .alert_o(a_o), .alert_oe_o(a_oe));
	tsc_conv_model u_conv (.run_i(conv_en), .want_i(want), .toggle_o(tgl), .temp_o(stemp));
	task automatic tk(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tk
	task automatic close_out();
		$display("Mismatches %0d, comparisons %0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: word %h, expected %h", $time, got, exp);
		end
	endtask : chk_word
	// Bounded wait for the pin level; running out ends the run
	task automatic chk_pin(input logic exp);
		int k = 0;
		while (pin !== exp && k < 64) begin
			tk(1);
			k++;
		end
		n_tests++;
		if (pin !== exp) begin
			bad_count++;
			$display("ERROR %0t: alert pin %b, expected %b", $time, pin, exp);
			close_out();
		end
	endtask : chk_pin
	// Frame of pointer, high byte, low byte; valid drops for a cycle after
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] w);
		wb = '{1'b1, 1'b1, a};
		tk(1);
		wb = '{1'b0, 1'b1, w[15:8]};
		tk(1);
		wb = '{1'b0, 1'b1, w[7:0]};
		tk(1);
		wb.valid = 1'b0;
		tk(1);
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		wb = '{1'b1, 1'b1, a};
		tk(1);
		wb.valid = 1'b0;
		tk(3);
		chk_word(rd_w, exp);
	endtask : rd_chk
	initial begin
		tk(20);
		reset_i = 1'b0;
		rd_chk(ADDR_CONFIG, 16'h0000);
		rd_chk(8'h06, 16'h0000);
		wr_reg(ADDR_HIGH, 16'hFFFF);
		rd_chk(ADDR_HIGH, 16'h1FFC);
		wr_reg(ADDR_CONFIG, 16'hF82E);
		rd_chk(ADDR_CONFIG, 16'h000E);
		chk_pin(1'b0);
		wr_reg(ADDR_HIGH, 16'h0190);
		wr_reg(ADDR_LOW, 16'h1E70);
		wr_reg(ADDR_CRIT, 16'h07D0);
		// Release point for every hysteresis code, comparator mode
		for (i = 0; i < 4; i++) begin
			wr_reg(ADDR_CONFIG, {5'h00, i[1:0], 9'h008});
			want = 13'h01A0;
			chk_pin(1'b0);
			want = 13'h0191 - hv[i];
			tk(40);
			chk_pin(1'b0);
			want = 13'h018F - hv[i];
			chk_pin(1'b1);
		end
		want = 13'h01A0;
		tk(40);
		rd_chk(ADDR_TEMP, 16'h41A0);
		want = 13'h1E60;
		chk_pin(1'b0);
		tk(40);
		rd_chk(ADDR_TEMP, 16'h3E60);
		want = 13'h07D0;
		tk(40);
		rd_chk(ADDR_TEMP, 16'hC7D0);
		// Enable and polarity combinations with the event asserted
		for (i = 0; i < 4; i++) begin
			wr_reg(ADDR_CONFIG, {12'h000, i[1], 1'b0, i[0], 1'b0});
			chk_pin(~(i[1] ^ i[0]));
			tk(4);
			rd_chk(ADDR_CONFIG, {11'h000, i[1], i[1], 1'b0, i[0], 1'b0});
		end
		want = 13'h0000;
		tk(40);
		wr_reg(ADDR_CONFIG, 16'h0009);
		chk_pin(1'b1);
		want = 13'h01A0;
		chk_pin(1'b0);
		want = 13'h0000;
		tk(40);
		chk_pin(1'b0);
		wr_reg(ADDR_CONFIG, 16'h0029);
		chk_pin(1'b1);
		wr_reg(ADDR_CONFIG, 16'h0008);
		want = 13'h01A0;
		chk_pin(1'b0);
		wr_reg(ADDR_CONFIG, 16'h0028);
		tk(40);
		chk_pin(1'b0);
		wr_reg(ADDR_HIGH, 16'h07C0);
		chk_pin(1'b1);
		// Interrupt mode: a clear above critical waits until critical trip drops
		wr_reg(ADDR_CONFIG, 16'h0009);
		want = 13'h07E0;
		chk_pin(1'b0);
		wr_reg(ADDR_CONFIG, 16'h0029);
		tk(40);
		chk_pin(1'b0);
		want = 13'h07C4;
		chk_pin(1'b1);
		wr_reg(ADDR_CONFIG, 16'h000D);
		want = 13'h07C8;
		tk(40);
		chk_pin(1'b1);
		want = 13'h07E0;
		chk_pin(1'b0);
		wr_reg(ADDR_CONFIG, 16'h002D);
		tk(40);
		chk_pin(1'b0);
		want = 13'h0000;
		chk_pin(1'b1);
		// Shutdown holds the last reading and stops the converter
		want = 13'h0100;
		tk(40);
		wr_reg(ADDR_CONFIG, 16'h0100);
		want = 13'h0050;
		tk(40);
		rd_chk(ADDR_TEMP, 16'h0100);
		chk_word({15'h0000, conv_en}, 16'h0000);
		wr_reg(ADDR_CONFIG, 16'h00C8);
		wr_reg(ADDR_HIGH, 16'h0200);
		rd_chk(ADDR_HIGH, 16'h07C0);
		wr_reg(ADDR_CRIT, 16'h0200);
		rd_chk(ADDR_CRIT, 16'h07D0);
		wr_reg(ADDR_CONFIG, 16'h0707);
		rd_chk(ADDR_CONFIG, 16'h00C8);
		reset_i = 1'b1;
		tk(2);
		reset_i = 1'b0;
		rd_chk(ADDR_CONFIG, 16'h0000);
		close_out();
	end
endmodule : test_temp_sensor_config_limits_alert
`default_nettype wire
